// file: timer_consts.svh
// constants: bus map, reset values, limits and timebase for the timer block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register byte offsets on the wishbone port
`define A_STATUS     8'h00
`define A_PSEL       8'h04
`define A_PIDX       8'h08
`define A_VIDX       8'h0c
`define A_VDATA      8'h10
`define A_PCONST     8'h20
`define A_PMEM       8'h40

// word-index fields of the byte offsets
`define PCONST_WORD  6'h08
`define PMEM_WORD    6'h10

// reset values
`define PSEL_RST     6'h00
`define PIDX_RST     24'h000000
`define PCONST_RST   32'h00000000
`define VIDX_RST     11'h000
`define PMEM_RST     16'h0000

// value-word numbers: timers at their number, counters at number + 1000
`define WN_ACC       11'h000
`define WN_FAST      11'h002
`define WN_SGL       11'h004
`define CNT_BASE     11'h3e8
`define CN_UP        11'h000
`define CN_UD        11'h001
`define CN_STG       11'h003

// saturation limits in bcd (tenths, hundredths, counts)
`define MAX_ACC      36'h099999999
`define MAX_FAST     36'h009999999
`define MAX_SGL      36'h000009999
`define MAX_CNT      36'h000009999
`define MAX_UD       36'h999999999

// timebase: clock period and hundredth-second period in ns
`define CLK_NS       50
`define TICK_10MS_NS 10000000
`define TENTH_LAST   4'h9

`endif

// file: timer_pkg.sv
// types shared by the timer and counter block
package timer_pkg;

    // nine bcd digits of a current value
    typedef logic [35:0] bcd_t;

    // level inputs from the controller program
    typedef struct packed {
        logic at_en;    // accum timer enable
        logic at_rst;   // accum timer reset
        logic aft_en;   // fast accum timer enable
        logic aft_rst;  // fast accum timer reset
        logic st_in;    // single-input timer input
        logic uc_cnt;   // up counter count
        logic uc_rst;   // up counter reset
        logic ud_up;    // bidir counter count up
        logic ud_dn;    // bidir counter count down
        logic ud_rst;   // bidir counter reset
        logic sc_cnt;   // step counter count
        logic sc_rst;   // step counter reset command
    } ctl_in_t;

    // done bits, one per element
    typedef struct packed {
        logic stg;
        logic ud;
        logic up;
        logic sgl;
        logic fast;
        logic acc;
    } done_t;

    // bus slave states, gray along the path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK  = 2'b01
    } wb_st_t;

endpackage

// file: bcd_step.sv
// one-step bcd up/down with saturation at a limit and at zero
`timescale 1ns/1ps
module bcd_step (
    // value and command
    input  wire logic [35:0] val_i,
    input  wire logic        up_i,
    input  wire logic        dn_i,
    input  wire logic [35:0] max_i,
    // result
    output logic      [35:0] nxt_o
);
    logic [9:0]  all9;  // lower digits all nine
    logic [9:0]  all0;  // lower digits all zero
    logic [35:0] incv;  // value plus one
    logic [35:0] decv;  // value minus one

    assign all9[0] = 1'b1;
    assign all0[0] = 1'b1;

    // per-digit carry and borrow chain
    genvar i;
    generate
        for (i = 0; i < 9; i++) begin : g_dig
            logic [3:0] d;
            assign d = val_i[4*i+3:4*i];
            assign all9[i+1] = all9[i] & (d == 4'h9);
            assign all0[i+1] = all0[i] & (d == 4'h0);
            assign incv[4*i+3:4*i] = !all9[i] ? d : (d == 4'h9) ? 4'h0 : d + 4'h1;
            assign decv[4*i+3:4*i] = !all0[i] ? d : (d == 4'h0) ? 4'h9 : d - 4'h1;
        end
    endgenerate

    // hold at the limit or at zero
    always_comb begin
        if (up_i && val_i != max_i) begin
            nxt_o = incv;
        end else if (dn_i && val_i != 36'h000000000) begin
            nxt_o = decv;
        end else begin
            nxt_o = val_i;
        end
    end
endmodule

// file: timer_counter_block.sv
// timers, event counters, preset store and wishbone slave
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_counter_block #(
    parameter int unsigned HUND_CYCLES = `TICK_10MS_NS / `CLK_NS
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               reset_n_i,
    // wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // program-side levels and done bits
    input  wire timer_pkg::ctl_in_t ctl_i,
    output timer_pkg::done_t        done_o
);
    import timer_pkg::*;

    // element order: accum, fast accum, single timer,
    // up counter, bidir counter, step counter
    localparam int NE = 6;                               // elements
    // divider wraps after this count
    localparam logic [17:0] HUND_LAST = 18'(HUND_CYCLES - 1);
    // elements whose presets span two memory words
    localparam logic [NE-1:0] DBL = 6'h13;               // two-word presets
    // saturation limits per element
    localparam bcd_t MAXV [NE] = '{`MAX_ACC, `MAX_FAST, `MAX_SGL,
                                   `MAX_CNT, `MAX_UD, `MAX_CNT};

    // timebase state
    logic [17:0]   div_q;             // hundredth divider
    logic          tick_h_q;          // hundredth tick
    logic [3:0]    tenth_q;           // hundredths within a tenth
    logic          tick_t_q;          // tenth tick
    // edge detection and step commands
    logic [3:0]    prev_q;            // last count levels
    logic [NE-1:0] inc;               // step up this cycle
    logic [NE-1:0] dec;               // step down this cycle
    logic [NE-1:0] clr;               // hold at zero
    // per-element values and presets
    bcd_t          cur_q [NE];        // current values
    bcd_t          cur_d [NE];        // next values
    bcd_t          step  [NE];        // stepped values
    bcd_t          pre   [NE];        // resolved presets
    logic [NE-1:0] done_d;            // next done bits
    logic [NE-1:0] done_q;            // done bits
    // software-visible registers
    logic [NE-1:0] psel_q;            // preset source per element
    logic [23:0]   pidx_q;            // preset memory index per element
    logic [31:0]   pconst_q [NE];     // constant presets
    logic [15:0]   pmem_q [16];       // preset memory words
    logic [10:0]   vidx_q;            // value word selector
    logic [15:0]   vword;             // selected value word
    logic [31:0]   rdata;             // read mux
    // bus slave
    wb_st_t        st_q;              // bus state
    logic          req;               // new bus request
    logic [5:0]    wa;                // word address

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        // start from the stored word
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b+:8] = nw[8*b+:8];
            end
        end
        return r;
    endfunction

    // hundredth-second tick from the clock
    // the tick stands for exactly one clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            div_q    <= 18'h00000;
            tick_h_q <= 1'b0;
        // last count of the period: wrap and pulse
        end else if (div_q == HUND_LAST) begin
            div_q    <= 18'h00000;
            tick_h_q <= 1'b1;
        end else begin
            div_q    <= div_q + 18'h00001;
            tick_h_q <= 1'b0;
        end
    end

    // tenth-second tick, every tenth hundredth
    // one clock behind the hundredth tick that ends a tenth
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tenth_q  <= 4'h0;
            tick_t_q <= 1'b0;
        end else begin
            tick_t_q <= tick_h_q && tenth_q == `TENTH_LAST;
            // count hundredths, wrap after the tenth
            if (tick_h_q) begin
                tenth_q <= (tenth_q == `TENTH_LAST) ? 4'h0 : tenth_q + 4'h1;
            end
        end
    end

    // count-input history for edge detection
    // resets low, the idle level, so no false edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prev_q <= 4'h0;
        end else begin
            // bit order: up, bidir up, bidir down, step
            prev_q <= {ctl_i.sc_cnt, ctl_i.ud_dn, ctl_i.ud_up, ctl_i.uc_cnt};
        end
    end

    // step and clear commands per element
    always_comb begin
        // defaults: no step, no clear
        inc = '0;
        dec = '0;
        clr = '0;
        // accum timer, tenths
        clr[0] = ctl_i.at_rst;
        inc[0] = ctl_i.at_en && tick_t_q;
        // fast accum timer, hundredths
        clr[1] = ctl_i.aft_rst;
        inc[1] = ctl_i.aft_en && tick_h_q;
        // single-input timer, tenths
        clr[2] = !ctl_i.st_in;
        inc[2] = ctl_i.st_in && tick_t_q;
        // up counter on rising edges
        clr[3] = ctl_i.uc_rst;
        inc[3] = ctl_i.uc_cnt && !prev_q[0];
        // bidir counter, other input must be low
        clr[4] = ctl_i.ud_rst;
        inc[4] = ctl_i.ud_up && !prev_q[1] && !ctl_i.ud_dn;
        dec[4] = ctl_i.ud_dn && !prev_q[2] && !ctl_i.ud_up;
        // step counter, cleared by reset command only
        clr[5] = ctl_i.sc_rst;
        inc[5] = ctl_i.sc_cnt && !prev_q[3];
    end

    // per-element stepper, preset and done compare
    // each element steps by at most one per clock
    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_el
            logic [3:0]  ix;      // preset memory index
            logic [31:0] pm;      // preset from memory
            bcd_step u_step (
                .val_i (cur_q[g]),
                .up_i  (inc[g]),
                .dn_i  (dec[g]),
                .max_i (MAXV[g]),
                .nxt_o (step[g])
            );
            // preset source: constant or memory word
            assign ix = pidx_q[4*g+:4];
            // double-word presets take the next word as high half
            assign pm = DBL[g] ? {pmem_q[ix + 4'h1], pmem_q[ix]} : {16'h0000, pmem_q[ix]};
            assign pre[g] = {4'h0, psel_q[g] ? pm : pconst_q[g]};
            // a clear wins over any step in the same cycle
            assign cur_d[g] = clr[g] ? 36'h000000000 : step[g];
            // bcd order matches binary order, so a plain compare works
            assign done_d[g] = !clr[g] && cur_d[g] >= pre[g];
        end
    endgenerate

    // current values
    // one register per element, loaded every clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int e = 0; e < NE; e++) begin
                cur_q[e] <= 36'h000000000;
            end
        end else begin
            for (int e = 0; e < NE; e++) begin
                cur_q[e] <= cur_d[e];
            end
        end
    end

    // done bits, updated with the values
    // registered so the done pins come from flops
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            done_q <= '0;
        end else begin
            done_q <= done_d;
        end
    end

    // element index order matches the done struct, lsb first
    assign done_o = done_t'(done_q);

    // value word lookup by word number
    // two-word values show their low digits first
    // unknown word numbers read as zero
    always_comb begin
        case (vidx_q)
            `WN_ACC:                 vword = cur_q[0][15:0];
            `WN_ACC + 11'h001:       vword = cur_q[0][31:16];
            `WN_FAST:                vword = cur_q[1][15:0];
            `WN_FAST + 11'h001:      vword = cur_q[1][31:16];
            `WN_SGL:                 vword = cur_q[2][15:0];
            `CNT_BASE + `CN_UP:      vword = cur_q[3][15:0];
            `CNT_BASE + `CN_UD:      vword = cur_q[4][15:0];
            `CNT_BASE + `CN_UD + 11'h001: vword = cur_q[4][31:16];
            `CNT_BASE + `CN_STG:     vword = cur_q[5][15:0];
            default:                 vword = 16'h0000;
        endcase
    end

    // word address; byte offset bits are ignored
    assign wa  = wb_adr_i[7:2];
    // a request is taken only while the slave is idle
    assign req = wb_cyc_i && wb_stb_i && st_q == ST_IDLE;

    // register read mux, unmapped reads as zero
    // status carries done bits and the bidir ninth digit
    always_comb begin
        rdata = 32'h00000000;
        if (wa == `A_STATUS >> 2) begin
            rdata = {20'h00000, cur_q[4][35:32], 2'b00, done_q};
        end else if (wa == `A_PSEL >> 2) begin
            rdata = {26'h0000000, psel_q};
        end else if (wa == `A_PIDX >> 2) begin
            rdata = {8'h00, pidx_q};
        end else if (wa == `A_VIDX >> 2) begin
            rdata = {21'h000000, vidx_q};
        end else if (wa == `A_VDATA >> 2) begin
            rdata = {16'h0000, vword};
        end else if (wa >= `PCONST_WORD && wa < `PCONST_WORD + 6'(NE)) begin
            rdata = pconst_q[3'(wa - `PCONST_WORD)];
        end else if (wa >= `PMEM_WORD && wa < `PMEM_WORD + 6'h10) begin
            rdata = {16'h0000, pmem_q[wa[3:0]]};
        end
    end

    // bus handshake: ack one cycle after the request, then drop
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_q     <= ST_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            case (st_q)
                // idle: take a request, answer next clock
                ST_IDLE: begin
                    if (req) begin
                        st_q     <= ST_ACK;
                        wb_ack_o <= 1'b1;
                        // writes return zero data
                        wb_dat_o <= wb_we_i ? 32'h00000000 : rdata;
                    end
                end
                // ack stood one clock: drop it
                ST_ACK: begin
                    st_q     <= ST_IDLE;
                    wb_ack_o <= 1'b0;
                end
                // unused encoding: back to idle
                default: begin
                    st_q     <= ST_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            psel_q <= `PSEL_RST;
            pidx_q <= `PIDX_RST;
            vidx_q <= `VIDX_RST;
        end else if (req && wb_we_i) begin
            if (wa == `A_PSEL >> 2) begin
                // one source bit per element
                psel_q <= 6'(merge({26'h0000000, psel_q}, wb_dat_i, wb_sel_i));
            end
            if (wa == `A_PIDX >> 2) begin
                // four index bits per element
                pidx_q <= 24'(merge({8'h00, pidx_q}, wb_dat_i, wb_sel_i));
            end
            if (wa == `A_VIDX >> 2) begin
                // word number of the value shown
                vidx_q <= 11'(merge({21'h000000, vidx_q}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // constant presets, writable at any time while counting
    // a new preset takes effect on the next compare
    // byte lanes merge into the stored word
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int e = 0; e < NE; e++) begin
                pconst_q[e] <= `PCONST_RST;
            end
        end else if (req && wb_we_i && wa >= `PCONST_WORD && wa < `PCONST_WORD + 6'(NE)) begin
            pconst_q[3'(wa - `PCONST_WORD)] <=
                merge(pconst_q[3'(wa - `PCONST_WORD)], wb_dat_i, wb_sel_i);
        end
    end

    // preset memory words
    // only the low half-word of each bus word is kept
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            for (int w = 0; w < 16; w++) begin
                pmem_q[w] <= `PMEM_RST;
            end
        end else if (req && wb_we_i && wa >= `PMEM_WORD && wa < `PMEM_WORD + 6'h10) begin
            pmem_q[wa[3:0]] <= 16'(merge({16'h0000, pmem_q[wa[3:0]]}, wb_dat_i, wb_sel_i));
        end
    end
endmodule

// file: timer_counter_block_monitor.sv
// assertion checker for the timer and counter block ports
`timescale 1ns/1ps
module timer_counter_block_monitor #(
    parameter int unsigned HUND_CYCLES = 4
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               reset_n_i,
    // wishbone handshake
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    // program levels and done bits
    input wire timer_pkg::ctl_in_t ctl_i,
    input wire timer_pkg::done_t   done_o
);
    import timer_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // request taken while slave idle
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // ack for exactly one cycle
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_once: assert property (bus_req |=> ack_once)
        else $error("ack not a single pulse after request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without strobe");
    chk_up_clear: assert property (ctl_i.uc_rst |=> !done_o.up)
        else $error("up done set during clear");
    chk_bidir_clear: assert property (ctl_i.ud_rst |=> !done_o.ud)
        else $error("bidir done set during clear");
    chk_step_clear: assert property (ctl_i.sc_rst |=> !done_o.stg)
        else $error("step done set during clear");
    chk_acc_clear: assert property (ctl_i.at_rst |=> !done_o.acc)
        else $error("accum done set during clear");
    chk_fast_clear: assert property (ctl_i.aft_rst |=> !done_o.fast)
        else $error("fast done set during clear");
    chk_single_drop: assert property (!ctl_i.st_in |=> !done_o.sgl)
        else $error("single done set with input low");
    chk_acc_freeze: assert property ((!ctl_i.at_en && !ctl_i.at_rst && !wb_cyc_i) [*3] |=> $stable(done_o.acc))
        else $error("accum done moved while disabled");
    chk_up_level: assert property ((ctl_i.uc_cnt && !ctl_i.uc_rst && !wb_cyc_i) [*3] |=> $stable(done_o.up))
        else $error("up done moved on held count level");
endmodule
bind timer_counter_block timer_counter_block_monitor #(.HUND_CYCLES(HUND_CYCLES)) i_mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ctl_i(ctl_i), .done_o(done_o));

// file: prog_model.sv
// program-side model driving enable, count and reset levels
`timescale 1ns/1ps
module prog_model (
    // clock
    input  wire logic          clk_i,
    // levels towards the block
    output timer_pkg::ctl_in_t ctl_o
);
    import timer_pkg::*;
    // all levels rest low, unused count inputs included
    initial begin
        ctl_o = '0;
    end
    // set one level just after an edge
    task automatic level(input int b, input logic v);
        @(posedge clk_i);
        ctl_o[b] <= v;
    endtask
    // count edge on one or two inputs: high one clock, low one clock
    // a mask keeps one write per edge, even when a equals b
    task automatic pulse2(input int a, input int b);
        ctl_in_t m;  // inputs that pulse
        m = '0;
        m[a] = 1'b1;
        m[b] = 1'b1;
        @(posedge clk_i);
        ctl_o <= ctl_in_t'(ctl_o | m);
        @(posedge clk_i);
        ctl_o <= ctl_in_t'(ctl_o & ~m);
    endtask
endmodule

// file: timer_counter_block_bench.sv
// self-checking bench for the timer and counter block
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_counter_block_bench;
    import timer_pkg::*;
    localparam int HC = 4; // short hundredth tick
    localparam int AT_EN = 11, AT_RST = 10, AFT_EN = 9, AFT_RST = 8, ST_IN = 7, UC_CNT = 6;
    localparam int UC_RST = 5, UD_UP = 4, UD_DN = 3, UD_RST = 2, SC_CNT = 1, SC_RST = 0;
    logic        clk_i;
    logic        reset_n_i;
    logic        cyc, stb, we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, wb_dat_o, v0;
    logic        wb_ack_o;
    ctl_in_t     ctl;
    done_t       done;
    int          error_cnt, compares;
    // device under test and program model
    timer_counter_block #(.HUND_CYCLES(HC)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctl_i(ctl), .done_o(done));
    prog_model p (.clk_i(clk_i), .ctl_o(ctl));
    // 20 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // verdict and end of run
    task automatic end_sim();
        $display("mismatches %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // range compare, exact when lo equals hi
    task automatic chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi, input string m);
        logic ok;
        ok = (g === lo) || (g === hi) || ((g > lo && g < hi) === 1'b1);
        compares++;
        if (!ok) begin
            error_cnt++;
            $display("unexpected %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            $display("unexpected %0t bus timeout", $time);
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, v0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input string m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, lo, hi, m);
    endtask
    // read a value word by number
    task automatic vw(input logic [10:0] n, input logic [31:0] lo, input logic [31:0] hi, input string m);
        wr(`A_VIDX, {21'h0, n});
        rd(`A_VDATA, lo, hi, m);
    endtask
    // reset values, unmapped and read-only places
    task automatic t_regs();
        rd(`A_PSEL, 0, 0, "psel reset");
        rd(`A_PIDX, 0, 0, "pidx reset");
        rd(`A_PMEM, 0, 0, "pmem reset");
        rd(8'h80, 0, 0, "unmapped read");
        wr(`A_STATUS, 32'hffffffff);
        rd(`A_STATUS, 32'h3b, 32'h3b, "status");
        chk({26'h0, done}, 32'h3b, 32'h3b, "done pins");
        wr(`A_PCONST + 8'h04, 32'h12345678);
        rd(`A_PCONST + 8'h04, 32'h12345678, 32'h12345678, "pconst");
    endtask
    // up counter edges, preset change, clear
    task automatic t_up();
        wr(`A_PCONST + 8'h0c, 32'h3);
        p.level(UC_CNT, 1'b1);
        cycles(5);
        p.level(UC_CNT, 1'b0);
        repeat (2) p.pulse2(UC_CNT, UC_CNT);
        vw(`CNT_BASE + `CN_UP, 3, 3, "up count");
        chk({31'h0, done.up}, 1, 1, "up done");
        wr(`A_PCONST + 8'h0c, 32'h4);
        cycles(2);
        chk({31'h0, done.up}, 0, 0, "up preset live");
        p.level(UC_RST, 1'b1);
        cycles(2);
        chk({31'h0, done.up}, 0, 0, "up clear done");
        vw(`CNT_BASE + `CN_UP, 0, 0, "up clear");
        p.level(UC_RST, 1'b0);
    endtask
    // up and step counters saturate
    task automatic t_sat();
        p.level(SC_RST, 1'b1);
        cycles(2);
        vw(`CNT_BASE + `CN_STG, 0, 0, "step clear");
        p.level(SC_RST, 1'b0);
        repeat (10001) p.pulse2(UC_CNT, SC_CNT);
        vw(`CNT_BASE + `CN_UP, 32'h9999, 32'h9999, "up max");
        vw(`CNT_BASE + `CN_STG, 32'h9999, 32'h9999, "step max");
    endtask
    // bidir counter with memory preset
    task automatic t_ud();
        wr(`A_PMEM + 8'h08, 32'h2);
        wr(`A_PIDX, 32'h00020000);
        wr(`A_PSEL, 32'h10);
        repeat (3) p.pulse2(UD_UP, UD_UP);
        vw(`CNT_BASE + `CN_UD, 3, 3, "bidir up");
        chk({31'h0, done.ud}, 1, 1, "bidir done");
        p.pulse2(UD_UP, UD_DN);
        vw(`CNT_BASE + `CN_UD, 3, 3, "bidir both");
        repeat (2) p.pulse2(UD_DN, UD_DN);
        vw(`CNT_BASE + `CN_UD, 1, 1, "bidir down");
        chk({31'h0, done.ud}, 0, 0, "bidir below");
        p.level(UD_RST, 1'b1);
        cycles(2);
        vw(`CNT_BASE + `CN_UD, 0, 0, "bidir clear");
        p.level(UD_RST, 1'b0);
        p.pulse2(UD_DN, UD_DN);
        vw(`CNT_BASE + `CN_UD, 0, 0, "bidir floor");
    endtask
    // accumulating and single timers
    task automatic t_tmr();
        wr(`A_PCONST, 32'h5);
        wr(`A_PCONST + 8'h08, 32'h1);
        p.level(AT_EN, 1'b1);
        p.level(AFT_EN, 1'b1);
        cycles(400);
        p.level(AT_EN, 1'b0);
        p.level(AFT_EN, 1'b0);
        vw(`WN_ACC, 32'h9, 32'h11, "accum tenths");
        vw(`WN_ACC + 11'h1, 0, 0, "accum high");
        vw(`WN_FAST, 32'h99, 32'h101, "fast hundredths");
        chk({31'h0, done.acc}, 1, 1, "accum done");
        wr(`A_VIDX, 32'h0);
        wb(1'b0, `A_VDATA, 32'h0, v0);
        cycles(200);
        rd(`A_VDATA, v0, v0, "accum frozen");
        p.level(AT_RST, 1'b1);
        p.level(AFT_RST, 1'b1);
        cycles(2);
        rd(`A_VDATA, 0, 0, "accum clear");
        vw(`WN_FAST, 0, 0, "fast clear");
        p.level(AT_RST, 1'b0);
        p.level(AFT_RST, 1'b0);
        p.level(ST_IN, 1'b1);
        cycles(120);
        vw(`WN_SGL, 32'h2, 32'h4, "single run");
        chk({31'h0, done.sgl}, 1, 1, "single done");
        p.level(ST_IN, 1'b0);
        cycles(2);
        chk({31'h0, done.sgl}, 0, 0, "single drop");
        vw(`WN_SGL, 0, 0, "single clear");
    endtask
    // main sequence
    initial begin
        reset_n_i = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        dat = 32'h0;
        error_cnt = 0;
        compares = 0;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_up();
        t_sat();
        t_ud();
        t_tmr();
        end_sim();
    end
endmodule
